// file: bcps_cmp.v
// signed relational compare for conditional branches
`timescale 1ns/10ps
`default_nettype none
`include "bcps_map.vh"

module bcps_cmp (
    input  wire [31:0] opa,
    input  wire [31:0] opb,
    input  wire [2:0]  cond,
    output reg         holds
);

    wire signed [31:0] sa;
    wire signed [31:0] sb;
    wire               lt;
    wire               eq;

    // both operands taken as two's complement
    assign sa = opa;
    assign sb = opb;
    assign lt = (sa < sb);
    assign eq = (sa == sb);

    // relop select; unknown codes never take
    always @* begin
        case (cond)
            `BCPS_CND_GT: holds = ~lt & ~eq;
            `BCPS_CND_LT: holds = lt;
            `BCPS_CND_EQ: holds = eq;
            `BCPS_CND_LE: holds = lt | eq;
            `BCPS_CND_GE: holds = ~lt;
            `BCPS_CND_NE: holds = ~eq;
            default:      holds = 1'b0;
        endcase
    end

endmodule
`default_nettype wire

// file: bcps_map.vh
// constants for the branch, call and return pc sequencer
`ifndef BCPS_MAP_VH
`define BCPS_MAP_VH

// instruction word layout, bit 0 of the format is word bit 47
`define BCPS_OPC_HI        47
`define BCPS_OPC_LO        40
`define BCPS_RX_HI         39
`define BCPS_RX_LO         36
`define BCPS_RYF_HI        35
`define BCPS_RYF_LO        32
`define BCPS_DSP_LONG_HI   31
`define BCPS_DSP_LONG_LO   0
`define BCPS_DSP_SHORT_HI  31
`define BCPS_DSP_SHORT_LO  16

// opcode classes
`define BCPS_GRP_BRANCH    3'h4
`define BCPS_LONG_BIT      4
`define BCPS_OP_REGISTER_RELATIVE_SUBROUTINE_OP      8'h53
`define BCPS_OP_RET        8'h57

// low nibble of branch-group opcodes
`define BCPS_FN_CALL       4'h3
`define BCPS_FN_LOOP       4'h7
`define BCPS_FN_JUMP       4'hb
`define BCPS_FN_NONE       4'hf
`define BCPS_FN_IMM_BIT    2

// condition codes handed to the comparator
`define BCPS_CND_GT        3'h0
`define BCPS_CND_LT        3'h1
`define BCPS_CND_EQ        3'h2
`define BCPS_CND_LE        3'h4
`define BCPS_CND_GE        3'h5
`define BCPS_CND_NE        3'h6

// instruction lengths in bytes
`define BCPS_LEN_REG       32'h00000002
`define BCPS_LEN_SHORT     32'h00000004
`define BCPS_LEN_LONG      32'h00000006

// issue stall after a wrong prediction, in cycles
`define BCPS_MISPRED_CYC   3'h4

`endif

// file: bcps_rf.sv
// register file partner: operands out, link and loop results in
`timescale 1ns/10ps
`default_nettype none
module bcps_rf (
    input  wire logic        CLK,
    input  wire logic [47:0] INSN_WORD,
    input  wire logic        LINK_WE,
    input  wire logic [3:0]  LINK_ADDR,
    input  wire logic [31:0] LINK_DATA,
    output logic      [31:0] RX_DATA,
    output logic      [31:0] RY_DATA
);
    logic [31:0] regs [0:15];
    // operands read in the issue cycle, no bypass
    assign RX_DATA = regs[INSN_WORD[39:36]];
    assign RY_DATA = regs[INSN_WORD[35:32]];
    // write-back lands one edge after LINK_WE rises; a word taken at that same edge still reads the old value
    always @(posedge CLK) begin
        if (LINK_WE) begin
            regs[LINK_ADDR] <= LINK_DATA;
        end
    end
endmodule
`default_nettype wire

// file: bcps_seq.v
// next-pc, prediction and link logic for branch, loop, call and return
//
// Overview of operation
// - the word holds opcode, first register, second field and a short or long displacement.
// - the target is own pc plus signed displacement, short ones sign-extended to 32 bits.
// - a branch not taken continues at pc plus the branch's own length.
// - for conditional ops the displacement lsb hints: set prefetches target, clear sequential.
// - a wrong prediction keeps the pc right but delays the next instruction by four cycles.
// - the unconditional jump always goes to and prefetches pc plus displacement, hint ignored.
// - the first register is compared signed with the second register or zero-extended field.
// - relations eq, lt, gt, ne, le and ge are offered; the branch is taken only if it holds.
// - loop adds 4-bit second field to the first register, writes back, branches if negative.
// - the relative call links the next address into the first register and jumps to target.
// - the register-relative call links pc plus 2 and jumps to pc plus the second register.
// - the return links pc plus 2 and jumps to the absolute address in the second register.
`timescale 1ns/10ps
`default_nettype none
`include "bcps_map.vh"

module bcps_seq (
    input  wire        CLK,
    input  wire        RESET_N,
    input  wire        INSN_VALID,
    input  wire [47:0] INSN_WORD,
    input  wire [31:0] INSN_PC,
    input  wire [31:0] RX_DATA,
    input  wire [31:0] RY_DATA,
    output reg         INSN_READY,
    output reg         XFER_VALID,
    output reg  [31:0] NEXT_PC,
    output reg  [31:0] PREFETCH_PC,
    output reg         MISPREDICT,
    output reg         LINK_WE,
    output reg  [3:0]  LINK_ADDR,
    output reg  [31:0] LINK_DATA
);

    // sequencer states, one-hot
    localparam [1:0] ST_RUN   = 2'b01;
    localparam [1:0] ST_STALL = 2'b10;

    // sequencer state and the dead-slot counter
    reg [1:0]  state_r;
    reg [1:0]  state_nxt;
    reg [2:0]  stall_cnt_r;
    reg [2:0]  stall_cnt_nxt;

    // decoded fields and shared terms
    wire [7:0]  opcode;
    wire [3:0]  first_reg;
    wire [3:0]  second_operand_field;
    wire [3:0]  fn;
    wire        is_group;
    wire        is_long;
    wire [31:0] disp;
    wire        hint;
    wire        take;

    // field extraction from the fetched word
    assign opcode               = INSN_WORD[`BCPS_OPC_HI:`BCPS_OPC_LO];
    assign first_reg            = INSN_WORD[`BCPS_RX_HI:`BCPS_RX_LO];
    assign second_operand_field = INSN_WORD[`BCPS_RYF_HI:`BCPS_RYF_LO];
    assign fn                   = opcode[3:0];
    assign is_group             = (opcode[7:5] == `BCPS_GRP_BRANCH);
    assign is_long              = opcode[`BCPS_LONG_BIT];

    // short displacement sign-extended to a full word
    assign disp = is_long ? INSN_WORD[`BCPS_DSP_LONG_HI:`BCPS_DSP_LONG_LO]
                          : {{16{INSN_WORD[`BCPS_DSP_SHORT_HI]}},
                             INSN_WORD[`BCPS_DSP_SHORT_HI:`BCPS_DSP_SHORT_LO]};
    assign hint = disp[0];
    assign take = INSN_VALID & INSN_READY;

    // decoded transfer classes
    wire is_call  = is_group & (fn == `BCPS_FN_CALL);
    wire is_loop  = is_group & (fn == `BCPS_FN_LOOP);
    wire is_jump  = is_group & (fn == `BCPS_FN_JUMP);
    wire is_cond  = is_group & ~is_call & ~is_loop & ~is_jump
                    & (fn != `BCPS_FN_NONE);
    // register-format transfers sit outside the branch group; their length is 2
    wire is_register_relative_subroutine_op = (opcode == `BCPS_OP_REGISTER_RELATIVE_SUBROUTINE_OP);
    wire is_ret   = (opcode == `BCPS_OP_RET);
    wire is_xfer  = is_call | is_loop | is_jump | is_cond | is_register_relative_subroutine_op | is_ret;

    // comparator operand b: register or zero-extended field
    wire        use_imm = fn[`BCPS_FN_IMM_BIT];
    wire [31:0] cmp_b   = use_imm ? {28'h0000000, second_operand_field} : RY_DATA;
    wire [2:0]  cmp_cond = {fn[3], fn[1:0]};
    wire        cmp_holds;

    bcps_cmp u_cmp (
        .opa   (RX_DATA),
        .opb   (cmp_b),
        .cond  (cmp_cond),
        .holds (cmp_holds)
    );

    // loop increment; sign of the new value decides
    // the sum is written back even when the branch is not taken
    wire [31:0] loop_sum = RX_DATA + {28'h0000000, second_operand_field};
    wire        loop_neg = loop_sum[31];

    // length of the instruction in bytes
    reg [31:0] ilen;
    always @* begin
        if (is_register_relative_subroutine_op | is_ret) begin
            ilen = `BCPS_LEN_REG;
        end else if (is_long) begin
            ilen = `BCPS_LEN_LONG;
        end else begin
            ilen = `BCPS_LEN_SHORT;
        end
    end

    // candidate addresses; a carry out of bit 31 wraps like the pc does
    wire [31:0] seq_pc = INSN_PC + ilen;
    wire [31:0] tgt_pc = INSN_PC + disp;
    wire [31:0] rel_pc = INSN_PC + RY_DATA;

    // resolved next pc, predicted prefetch address and link write
    reg [31:0] next_pc_nxt;
    reg [31:0] pref_pc_nxt;
    reg        link_we_nxt;
    reg [31:0] link_data_nxt;
    reg        mispred_nxt;
    reg        cond_taken;

    always @* begin
        next_pc_nxt   = seq_pc;
        pref_pc_nxt   = seq_pc;
        link_we_nxt   = 1'b0;
        link_data_nxt = seq_pc;
        cond_taken    = 1'b0;
        mispred_nxt   = 1'b0;
        if (is_jump) begin
            next_pc_nxt = tgt_pc;
            pref_pc_nxt = tgt_pc;
        end else if (is_call) begin
            next_pc_nxt = tgt_pc;
            pref_pc_nxt = tgt_pc;
            link_we_nxt = 1'b1;
        end else if (is_register_relative_subroutine_op) begin
            next_pc_nxt = rel_pc;
            pref_pc_nxt = rel_pc;
            link_we_nxt = 1'b1;
        end else if (is_ret) begin
            next_pc_nxt = RY_DATA;
            pref_pc_nxt = RY_DATA;
            link_we_nxt = 1'b1;
        end else if (is_cond | is_loop) begin
            cond_taken    = is_loop ? loop_neg : cmp_holds;
            next_pc_nxt   = cond_taken ? tgt_pc : seq_pc;
            pref_pc_nxt   = hint ? tgt_pc : seq_pc;
            mispred_nxt   = (hint != cond_taken);
            link_we_nxt   = is_loop;
            link_data_nxt = loop_sum;
        end
    end

    // stall control: four dead issue slots after a wrong guess
    // no take can land while stalled, since ready is already low for the whole count
    always @* begin
        state_nxt     = state_r;
        stall_cnt_nxt = stall_cnt_r;
        case (state_r)
            ST_RUN: begin
                if (take & is_xfer & mispred_nxt) begin
                    state_nxt     = ST_STALL;
                    stall_cnt_nxt = `BCPS_MISPRED_CYC;
                end
            end
            ST_STALL: begin
                stall_cnt_nxt = stall_cnt_r - 3'h1;
                if (stall_cnt_r == 3'h1) begin
                    state_nxt = ST_RUN;
                end
            end
            default: begin
                state_nxt     = ST_RUN;
                stall_cnt_nxt = 3'h0;
            end
        endcase
    end

    // ready is registered so that it leaves a flop; it drops the cycle after the branch
    wire ready_nxt = (state_nxt == ST_RUN);

    // state and output registers
    always @(posedge CLK) begin
        if (!RESET_N) begin
            // ready stays low in reset so the fetch side cannot offer too early
            state_r     <= ST_RUN;
            stall_cnt_r <= 3'h0;
            INSN_READY  <= 1'b0;
            XFER_VALID  <= 1'b0;
            NEXT_PC     <= 32'h00000000;
            PREFETCH_PC <= 32'h00000000;
            MISPREDICT  <= 1'b0;
            LINK_WE     <= 1'b0;
            LINK_ADDR   <= 4'h0;
            LINK_DATA   <= 32'h00000000;
        end else begin
            state_r     <= state_nxt;
            stall_cnt_r <= stall_cnt_nxt;
            INSN_READY  <= ready_nxt;
            XFER_VALID  <= take & is_xfer;
            MISPREDICT  <= take & is_xfer & mispred_nxt;
            LINK_WE     <= take & link_we_nxt;
            // held results move only on a transfer; plain ops leave them as they were
            if (take & is_xfer) begin
                NEXT_PC     <= next_pc_nxt;
                PREFETCH_PC <= pref_pc_nxt;
                LINK_ADDR   <= first_reg;
                LINK_DATA   <= link_data_nxt;
            end
        end
    end

endmodule
`default_nettype wire

// file: bcps_seq_sva.sv
// port-level assertion checker for the pc sequencer
`timescale 1ns/10ps
`default_nettype none
module bcps_seq_chk (
    input wire logic        CLK,
    input wire logic        RESET_N,
    input wire logic        INSN_VALID,
    input wire logic [47:0] INSN_WORD,
    input wire logic [31:0] INSN_PC,
    input wire logic [31:0] RX_DATA,
    input wire logic [31:0] RY_DATA,
    input wire logic        INSN_READY,
    input wire logic        XFER_VALID,
    input wire logic [31:0] NEXT_PC,
    input wire logic [31:0] PREFETCH_PC,
    input wire logic        MISPREDICT,
    input wire logic        LINK_WE,
    input wire logic [3:0]  LINK_ADDR,
    input wire logic [31:0] LINK_DATA
);
    // decoded views of the offered word
    wire        tk  = INSN_VALID && INSN_READY;
    wire [7:0]  op  = INSN_WORD[47:40];
    wire [3:0]  rx  = INSN_WORD[39:36];
    wire [31:0] fld = {28'h0, INSN_WORD[35:32]};
    wire [31:0] sd  = {{16{INSN_WORD[31]}}, INSN_WORD[31:16]};
    wire [31:0] ld  = INSN_WORD[31:0];
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    mis_xfer_a: assert property (MISPREDICT |-> XFER_VALID)
        else $error("mispredict without transfer");
    stall_len_a: assert property (MISPREDICT |-> !INSN_READY [*4] ##1 INSN_READY)
        else $error("stall length wrong");
    jump_tgt_a: assert property (tk && op == 8'h8b |=>
        XFER_VALID && !MISPREDICT && NEXT_PC == $past(INSN_PC) + $past(sd))
        else $error("jump target wrong");
    long_tgt_a: assert property (tk && op == 8'h9b |=>
        NEXT_PC == $past(INSN_PC) + $past(ld))
        else $error("long target wrong");
    call_link_a: assert property (tk && op == 8'h83 |=> LINK_WE &&
        LINK_DATA == $past(INSN_PC) + 32'h4 && LINK_ADDR == $past(rx))
        else $error("call link wrong");
    register_relative_subroutine_op_a: assert property (tk && op == 8'h53 |=> LINK_DATA == $past(INSN_PC) + 32'h2
        && NEXT_PC == $past(INSN_PC) + $past(RY_DATA))
        else $error("register call wrong");
    ret_a: assert property (tk && op == 8'h57 |=> LINK_WE && NEXT_PC == $past(RY_DATA))
        else $error("return target wrong");
    loop_sum_a: assert property (tk && op == 8'h87 |=>
        LINK_WE && LINK_DATA == $past(RX_DATA) + $past(fld))
        else $error("loop sum wrong");
    pf_hit_a: assert property (XFER_VALID && !MISPREDICT |-> PREFETCH_PC == NEXT_PC)
        else $error("prefetch disagrees");
endmodule
bind bcps_seq bcps_seq_chk i_chk (.CLK, .RESET_N, .INSN_VALID, .INSN_WORD, .INSN_PC,
    .RX_DATA, .RY_DATA, .INSN_READY, .XFER_VALID, .NEXT_PC, .PREFETCH_PC, .MISPREDICT,
    .LINK_WE, .LINK_ADDR, .LINK_DATA);
`default_nettype wire

// file: bcps_seq_tb.sv
// self-checking bench for the pc sequencer
`timescale 1ns/10ps
`default_nettype none
module bcps_seq_tb;
    logic        clk, rst_n, vld, rdy, xv, mis, lwe;
    logic [47:0] word;
    logic [31:0] pc, rxd, ryd, npc, ppc, ldat;
    logic [3:0]  ladr;
    int          failures, compares;
    bcps_seq i_dut (.CLK(clk), .RESET_N(rst_n), .INSN_VALID(vld), .INSN_WORD(word),
        .INSN_PC(pc), .RX_DATA(rxd), .RY_DATA(ryd), .INSN_READY(rdy), .XFER_VALID(xv),
        .NEXT_PC(npc), .PREFETCH_PC(ppc), .MISPREDICT(mis), .LINK_WE(lwe),
        .LINK_ADDR(ladr), .LINK_DATA(ldat));
    bcps_rf i_rf (.CLK(clk), .INSN_WORD(word), .LINK_WE(lwe), .LINK_ADDR(ladr),
        .LINK_DATA(ldat), .RX_DATA(rxd), .RY_DATA(ryd));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    // offer one word, hold it until taken, then look one cycle later
    task issue(input logic [7:0] op, input logic [3:0] rx, input logic [3:0] ry,
               input logic [31:0] d, input logic [31:0] p);
        int n;
        n = 0;
        @(posedge clk);
        vld <= 1'b1;
        word <= {op, rx, ry, d};
        pc <= p;
        #1;
        // ready is looked at once settled; the edge after it is seen high takes the word
        while (rdy !== 1'b1 && n < 20) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n >= 20) failures++;
        @(posedge clk);
        vld <= 1'b0;
        #1;
    endtask
    task res(input logic [31:0] n, input logic [31:0] f, input logic m);
        chk("xfer", 32'h1, {31'h0, xv});
        chk("next_pc", n, npc);
        chk("prefetch", f, ppc);
        chk("mispredict", {31'h0, m}, {31'h0, mis});
    endtask
    task lnk(input logic [3:0] a, input logic [31:0] v);
        chk("link_we", 32'h1, {31'h0, lwe});
        chk("link_addr", {28'h0, a}, {28'h0, ladr});
        chk("link_data", v, ldat);
    endtask
    task stall;
        chk("ready", 32'h0, {31'h0, rdy});
        repeat (3) @(posedge clk);
        #1;
        chk("ready", 32'h0, {31'h0, rdy});
        @(posedge clk);
        #1;
        chk("ready", 32'h1, {31'h0, rdy});
    endtask
    // all six relations, register then immediate, -2 against 3 signed
    task t_cond;
        logic [3:0] fn [0:11];
        int i;
        fn = '{4'h0, 4'h1, 4'h2, 4'h8, 4'h9, 4'ha, 4'h4, 4'h5, 4'h6, 4'hc, 4'hd, 4'he};
        i_rf.regs[1] = 32'hfffffffe;
        i_rf.regs[3] = 32'h00000003;
        for (i = 0; i < 12; i++) begin
            issue(8'h80 | {4'h0, fn[i]}, 4'h1, 4'h3, 32'h00400000, 32'h00001000);
            res(i[0] ? 32'h00001040 : 32'h00001004, 32'h00001004, i[0]);
            chk("link_we", 32'h0, {31'h0, lwe});
            if (i[0]) stall;
        end
        $display("t_cond done");
    endtask
    // long form, hint set: right guess, then wrong guess
    task t_long;
        issue(8'h91, 4'h1, 4'h3, 32'hfffff001, 32'h00002000);
        res(32'h00001001, 32'h00001001, 1'b0);
        issue(8'h90, 4'h1, 4'h3, 32'hfffff001, 32'h00002000);
        res(32'h00002006, 32'h00001001, 1'b1);
        stall;
        $display("t_long done");
    endtask
    task t_jump;
        issue(8'h8b, 4'h1, 4'h3, 32'hff000000, 32'h00003000);
        res(32'h00002f00, 32'h00002f00, 1'b0);
        issue(8'h9b, 4'h1, 4'h3, 32'h00010000, 32'h00003000);
        res(32'h00013000, 32'h00013000, 1'b0);
        $display("t_jump done");
    endtask
    task t_call;
        issue(8'h83, 4'h4, 4'h9, 32'h01000000, 32'h00004000);
        res(32'h00004100, 32'h00004100, 1'b0);
        lnk(4'h4, 32'h00004004);
        issue(8'h93, 4'h4, 4'h9, 32'h00000010, 32'h00004000);
        res(32'h00004010, 32'h00004010, 1'b0);
        lnk(4'h4, 32'h00004006);
        $display("t_call done");
    endtask
    task t_reg;
        i_rf.regs[6] = 32'h00000100;
        issue(8'h53, 4'h5, 4'h6, 32'h00000000, 32'h00005000);
        res(32'h00005100, 32'h00005100, 1'b0);
        lnk(4'h5, 32'h00005002);
        issue(8'h57, 4'h7, 4'h6, 32'h00000000, 32'h00005000);
        res(32'h00000100, 32'h00000100, 1'b0);
        lnk(4'h7, 32'h00005002);
        $display("t_reg done");
    endtask
    // second pass relies on the partner's write-back of the first sum
    task t_loop;
        i_rf.regs[2] = 32'hfffffffd;
        issue(8'h87, 4'h2, 4'h2, 32'h00210000, 32'h00006000);
        res(32'h00006021, 32'h00006021, 1'b0);
        lnk(4'h2, 32'hffffffff);
        issue(8'h87, 4'h2, 4'h2, 32'h00210000, 32'h00006000);
        res(32'h00006004, 32'h00006021, 1'b1);
        lnk(4'h2, 32'h00000001);
        stall;
        $display("t_loop done");
    endtask
    // empty slot and a neighbouring non-branch op are taken but resolve nothing
    task t_none;
        issue(8'h8f, 4'h1, 4'h3, 32'h00400000, 32'h00008000);
        chk("xfer", 32'h0, {31'h0, xv});
        chk("link_we", 32'h0, {31'h0, lwe});
        chk("next_pc", 32'h00006004, npc);
        issue(8'h50, 4'h1, 4'h3, 32'h00000000, 32'h00008000);
        chk("xfer", 32'h0, {31'h0, xv});
        chk("ready", 32'h1, {31'h0, rdy});
        $display("t_none done");
    endtask
    // reset in the middle of a stall clears results; next word is taken normally
    task t_rst;
        issue(8'h81, 4'h1, 4'h3, 32'h00400000, 32'h00007000);
        res(32'h00007040, 32'h00007004, 1'b1);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk("ready", 32'h0, {31'h0, rdy});
        chk("next_pc", 32'h0, npc);
        @(posedge clk);
        rst_n <= 1'b1;
        issue(8'h8b, 4'h1, 4'h3, 32'h00100000, 32'h00007000);
        res(32'h00007010, 32'h00007010, 1'b0);
        $display("t_rst done");
    endtask
    task end_of_test;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        rst_n = 1'b0;
        vld = 1'b0;
        word = 48'h0;
        pc = 32'h0;
        failures = 0;
        compares = 0;
        repeat (12) @(posedge clk);
        chk("ready", 32'h0, {31'h0, rdy});
        rst_n <= 1'b1;
        t_cond;
        t_long;
        t_jump;
        t_call;
        t_reg;
        t_loop;
        t_none;
        t_rst;
        end_of_test;
    end
    // hang guard, far beyond the hundred or so cycles the tests need
    initial begin
        #100000;
        failures++;
        end_of_test;
    end
endmodule
`default_nettype wire
